// >>> common/mspi_pkg.sv
// Shared constants and types of the serial port in master SPI mode.
// Assumes one system clock and synchronous control inputs.
package mspi_pkg;
    // ==========================================
    // Frame and divisor layout
    localparam int DATA_BITS = 8;
    localparam int DIV_W = 12;
    localparam int TX_DEPTH = 4;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SPI = 2'h3;
    // ==========================================
    // Reset values and receive buffer fill levels
    localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
    localparam logic [1:0] RX_EMPTY = 2'h0;
    localparam logic [1:0] RX_FULL = 2'h2;
    // ==========================================
    // Transfer controller states
    typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;
endpackage

// >>> rtl/usart_master_spi.sv
// Master SPI mode of the serial port: transmit queue, shift engine,
// clock generator and a two-entry receive buffer.
// Assumes all control inputs are synchronous to mclk; software pulses
// the data write, data read and completion-clear strobes for one cycle.
`timescale 1ns/100ps

// ==========================================
// Transmit queue
module tx_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic ready_reg;
    logic valid_reg;
    wire push = inValid && ready_reg;
    wire pop = outReady && valid_reg;

    // Occupancy after this cycle
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign inReady = ready_reg;
    assign outValid = valid_reg;
    assign outData = mem[rdPtr_reg];

    // pointers and flags, ready set by reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            ready_reg <= 1'b1;
            valid_reg <= 1'b0;
        end else begin
            if (push) wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            if (pop) rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
            count_reg <= count_next;
            ready_reg <= (count_next != FULL_CNT);
            valid_reg <= (count_next != '0);
        end
    end

    // Storage
    always_ff @(posedge mclk) begin
        if (push) mem[wrPtr_reg] <= inData;
    end
endmodule

// ==========================================
// Master SPI transfer controller
module usart_master_spi
    import mspi_pkg::*;
#(
    parameter int FIFO_DEPTH = TX_DEPTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Configuration
    input wire logic [1:0] portModeSelect,
    input wire logic transmitterEnable,
    input wire logic receiverEnable,
    input wire logic clockPhaseSelect,
    input wire logic clockPolaritySelect,
    input wire logic bitOrderSelect,
    input wire logic [DIV_W-1:0] baudDivisor,
    // Data access
    input wire logic dataWrite,
    input wire logic [DATA_BITS-1:0] dataIn,
    input wire logic dataRead,
    output logic [DATA_BITS-1:0] rxData,
    // Status
    input wire logic txCompleteClear,
    input wire logic txCompleteAck,
    output logic transmitBufferEmptyFlag,
    output logic transmitCompleteFlag,
    output logic receiveCompleteFlag,
    output logic framingErrorFlag,
    output logic overrunErrorFlag,
    output logic parityErrorFlag,
    // Serial pins
    output logic serialClockPin,
    output logic serialOutPin,
    output logic serialOutPinOe,
    input wire logic serialInPin
);
    // Next shift image for either bit order
    function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic b, input logic lsbFirst);
        shiftIn = lsbFirst ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    xfer_state_t state_reg;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] baudCnt_reg;
    logic [3:0] edgeCnt_reg;
    logic [7:0] txShift_reg;
    logic [7:0] rxShift_reg;
    logic [7:0] rxTail_reg;
    logic [7:0] rxHead_reg;
    logic [1:0] rxCount_reg;
    logic [1:0] rxCount_next;
    logic sclk_reg;
    logic mosi_reg;
    logic oe_reg;
    logic txc_reg;
    logic rxc_reg;
    logic zeroFlags_reg;
    logic qValid;
    logic [7:0] qData;
    logic qReady;

    // ==========================================
    // Mode decode and transfer events
    // both select bits
    wire spiMode = (portModeSelect == MODE_SPI);
    wire active = spiMode && transmitterEnable;
    wire shifting = (state_reg == ST_SHIFT);
    wire tick = shifting && (baudCnt_reg == '0);
    wire leading = ~edgeCnt_reg[0];
    wire sampleEdge = tick && (leading ^ clockPhaseSelect);
    wire setupEdge = tick && !(leading ^ clockPhaseSelect);
    wire frameEnd = tick && (edgeCnt_reg == LAST_EDGE);
    wire loadOk = active && (!shifting || frameEnd);
    wire load = loadOk && qValid;
    wire [7:0] rxShiftNext = sampleEdge ? shiftIn(rxShift_reg, serialInPin, bitOrderSelect) : rxShift_reg;
    wire rxPush = frameEnd && receiverEnable;
    wire rxPop = dataRead && (rxCount_reg != RX_EMPTY);
    wire txOut = bitOrderSelect ? txShift_reg[0] : txShift_reg[7];
    wire txcSet = frameEnd && !qValid;

    assign qReady = loadOk;

    tx_byte_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) txQueue (
        .mclk(mclk),
        .rst(rst),
        .inValid(dataWrite),
        .inReady(transmitBufferEmptyFlag),
        .inData(dataIn),
        .outValid(qValid),
        .outReady(qReady),
        .outData(qData)
    );

    assign rxCount_next = !receiverEnable ? RX_EMPTY :
                          (rxPush && !rxPop && rxCount_reg != RX_FULL) ? rxCount_reg + 2'h1 :
                          (!rxPush && rxPop) ? rxCount_reg - 2'h1 : rxCount_reg;

    assign serialClockPin = sclk_reg;
    assign serialOutPin = mosi_reg;
    assign serialOutPinOe = oe_reg;
    assign rxData = rxHead_reg;
    assign transmitCompleteFlag = txc_reg;
    assign receiveCompleteFlag = rxc_reg;
    assign framingErrorFlag = zeroFlags_reg;
    assign overrunErrorFlag = zeroFlags_reg;
    assign parityErrorFlag = zeroFlags_reg;

    // ==========================================
    // Baud generator
    // divisor resets to zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_reg <= DIV_RESET;
            baudCnt_reg <= DIV_RESET;
        end else begin
            div_reg <= baudDivisor;
            if (!shifting || tick) baudCnt_reg <= div_reg;
            else baudCnt_reg <= baudCnt_reg - 1'b1;
        end
    end

    // ==========================================
    // Common transfer controller
    // frame sequencing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            edgeCnt_reg <= '0;
        end else if (load) begin
            state_reg <= ST_SHIFT;
            edgeCnt_reg <= '0;
        end else if (frameEnd || !active && !shifting) begin
            state_reg <= ST_IDLE;
            edgeCnt_reg <= '0;
        end else if (tick) begin
            edgeCnt_reg <= edgeCnt_reg + 4'h1;
        end
    end

    // Clock pin: toggles on each edge, rests at polarity
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) sclk_reg <= 1'b0;
        else if (!shifting) sclk_reg <= clockPolaritySelect;
        else if (tick) sclk_reg <= ~sclk_reg;
    end

    // Transmit shifter and data line
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            txShift_reg <= '0;
            mosi_reg <= 1'b1;
        end else if (load) begin
            txShift_reg <= clockPhaseSelect ? qData : shiftIn(qData, 1'b0, bitOrderSelect);
            mosi_reg <= clockPhaseSelect ? (frameEnd ? mosi_reg : 1'b1) : (bitOrderSelect ? qData[0] : qData[7]);
        end else if ((frameEnd && !clockPhaseSelect) || !shifting) begin
            // idle high; phase one holds its last bit across the final sample edge
            mosi_reg <= 1'b1;
        end else if (setupEdge) begin
            mosi_reg <= txOut;
            txShift_reg <= shiftIn(txShift_reg, 1'b0, bitOrderSelect);
        end
    end

    // pin ownership as in the normal modes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) oe_reg <= 1'b0;
        else oe_reg <= active || shifting;
    end

    // ==========================================
    // Receive path
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxShift_reg <= '0;
            rxHead_reg <= '0;
            rxTail_reg <= '0;
            rxCount_reg <= RX_EMPTY;
            rxc_reg <= 1'b0;
        end else begin
            rxShift_reg <= rxShiftNext;
            rxCount_reg <= rxCount_next;
            rxc_reg <= (rxCount_next != RX_EMPTY);
            if (rxPop) rxHead_reg <= rxTail_reg;
            if (rxPush && (rxCount_reg == RX_EMPTY || rxCount_reg == 2'h1 && rxPop)) rxHead_reg <= rxShiftNext;
            else if (rxPush && (rxCount_reg == 2'h1 || rxCount_reg == RX_FULL && rxPop)) rxTail_reg <= rxShiftNext;
        end
    end

    // ==========================================
    // Status flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            txc_reg <= 1'b0;
            zeroFlags_reg <= 1'b0;
        end else begin
            if (txcSet) txc_reg <= 1'b1;
            else if (txCompleteClear || txCompleteAck) txc_reg <= 1'b0;
            zeroFlags_reg <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    AST_SCLK_IDLE: assert property (@(posedge mclk) disable iff (rst)
        !shifting && $past(!shifting) && !$past(rst) |-> sclk_reg == $past(clockPolaritySelect))
        else $error("clock not at idle level");
    AST_MODE_GATE: assert property (@(posedge mclk) disable iff (rst)
        !spiMode && !shifting |=> !shifting)
        else $error("transfer started outside SPI mode");
    AST_ERR_ZERO: assert property (@(posedge mclk) disable iff (rst)
        ##1 !(framingErrorFlag || overrunErrorFlag || parityErrorFlag))
        else $error("error flag set");
    AST_TXC_SET: assert property (@(posedge mclk) disable iff (rst)
        txcSet |=> transmitCompleteFlag)
        else $error("completion flag missed");
    AST_BACK2BACK: assert property (@(posedge mclk) disable iff (rst)
        frameEnd && qValid && active |=> shifting && edgeCnt_reg == 4'h0 && !transmitCompleteFlag[*1])
        else $error("queued byte not started");
    AST_MOSI_IDLE: assert property (@(posedge mclk) disable iff (rst)
        frameEnd && !load |-> ##2 (mosi_reg || $past(load)))
        else $error("data line not idle high");
    AST_OUT_OE: assert property (@(posedge mclk) disable iff (rst)
        active |=> serialOutPinOe)
        else $error("output pin not driven");
    AST_RX_OVF: assert property (@(posedge mclk) disable iff (rst)
        rxPush && !dataRead && rxCount_reg == RX_FULL |=> $stable(rxData) && $stable(rxTail_reg))
        else $error("buffered byte overwritten");
    AST_BAUD: assert property (@(posedge mclk) disable iff (rst)
        tick && !frameEnd && $stable(div_reg) |=> baudCnt_reg == div_reg)
        else $error("half period wrong");
    AST_FRAME_LEN: assert property (@(posedge mclk) disable iff (rst)
        load && div_reg == '0 && $stable(div_reg) |-> ##16 frameEnd || !$past(shifting))
        else $error("frame length wrong");
endmodule

// >>> dv/spi_slave_model.sv
// ==========================================
// SPI slave seen from the master's serial pins
// Assumes the bench tells it the phase and order and resyncs it after
// every reset or polarity change, since the link has no select line.
`timescale 1ns/100ps
module spi_slave_model (
    // Serial link
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Setup from the bench
    input wire logic cpha,
    input wire logic lsbFirst,
    input wire logic resync,
    input wire logic [7:0] reply,
    // Observed traffic
    output logic [7:0] got,
    output int frames
);
    int edges;
    int setups;
    int idx;
    logic [7:0] shiftIn;
    // sample and setup edges, eight bits a frame
    always @(sclk or posedge resync) begin
        if (resync) begin
            edges = 0;
            setups = 0;
        end else begin
            if ((edges % 2 == 0) != cpha) shiftIn = lsbFirst ? {mosi, shiftIn[7:1]} : {shiftIn[6:0], mosi};
            else setups++;
            edges++;
            if (edges == 16) begin
                got = shiftIn;
                frames++;
                edges = 0;
                setups = 0;
            end
        end
    end
    // Reply bit, or with phase one the inverse of the last bit outside a frame
    assign idx = cpha ? setups - 1 : setups;
    assign miso = (idx >= 0 && idx < 8) ? reply[lsbFirst ? idx : 7 - idx] : ~reply[lsbFirst ? 7 : 0];
endmodule

// >>> dv/usart_master_spi_bench.sv
// ==========================================
// Self-checking bench of the master SPI mode with a reference model
// Assumes the design's control inputs are sampled on the rising mclk edge.
`timescale 1ns/100ps
module usart_master_spi_bench;
    import mspi_pkg::*;
    logic mclk, rst, txEn, rxEn, cpha, cpol, lsb, wr, rd, txcClr, txcAck, resync;
    logic [1:0] modeSel;
    logic [DIV_W-1:0] div;
    logic [7:0] din, reply, got, rxData;
    logic tbe, tcf, rcf, fe, ovr, par, sclk, mosi, oe, miso, lastClk;
    int frames, nFail, numChecks, run, halfSeen, cycles, f0;
    int seed = 12;
    logic [7:0] expTx[$];
    logic [7:0] expRx[$];
    // ==========================================
    // Design and partner
    usart_master_spi i_usart_master_spi (.mclk, .rst, .portModeSelect(modeSel), .transmitterEnable(txEn),
        .receiverEnable(rxEn), .clockPhaseSelect(cpha), .clockPolaritySelect(cpol), .bitOrderSelect(lsb),
        .baudDivisor(div), .dataWrite(wr), .dataIn(din), .dataRead(rd), .rxData, .txCompleteClear(txcClr),
        .txCompleteAck(txcAck), .transmitBufferEmptyFlag(tbe), .transmitCompleteFlag(tcf),
        .receiveCompleteFlag(rcf), .framingErrorFlag(fe), .overrunErrorFlag(ovr), .parityErrorFlag(par),
        .serialClockPin(sclk), .serialOutPin(mosi), .serialOutPinOe(oe), .serialInPin(miso));
    spi_slave_model i_spi_slave_model (.sclk, .mosi, .miso, .cpha, .lsbFirst(lsb), .resync, .reply,
        .got, .frames);
    // ==========================================
    // Clock, half-period monitor and timeout
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (sclk !== lastClk) begin
            halfSeen = run;
            run = 1;
        end else run++;
        lastClk = sclk;
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            printVerdict();
        end
    end
    // Every finished frame against the model
    always @(frames) begin
        check("mosiByte", expTx.pop_front(), got);
        if (rxEn === 1'b1 && expRx.size() < 2) expRx.push_back(reply);
        reply = 8'($random(seed));
    end
    // ==========================================
    // Shared tasks
    task automatic tick(int n = 1);
        repeat (n) @(posedge mclk);
        #5;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
        numChecks++;
        if (exp !== seen) begin
            nFail++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic printVerdict();
        if (nFail == 0 && numChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic writeBurst(int n);
        txcClr = 1'b1;
        tick();
        txcClr = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = 8'($random(seed));
            if (tbe === 1'b1) expTx.push_back(din);
            wr = 1'b1;
            tick();
        end
        wr = 1'b0;
    endtask
    task automatic waitDone();
        int n = 0;
        while (tcf !== 1'b1 && n < 3000) begin
            tick();
            n++;
        end
        tick(2);
        check("doneInTime", 1, n < 3000);
    endtask
    task automatic readRx();
        check("rxFlag", 1, rcf);
        check("rxData", expRx.pop_front(), rxData);
        rd = 1'b1;
        tick();
        rd = 1'b0;
        tick();
    endtask
    task automatic doReset();
        resync = 1'b1;
        rst = 1'b1;
        tick(10);
        rst = 1'b0;
        expTx.delete();
        expRx.delete();
        tick(2);
        resync = 1'b0;
        check("flagsAtReset", 4'h8, {tbe, tcf, rcf, oe});
        check("errFlags", 0, {fe, ovr, par});
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {txEn, rxEn, cpha, cpol, lsb, wr, rd, txcClr, txcAck} = '0;
        modeSel = MODE_SPI;
        div = DIV_RESET;
        din = 8'h00;
        reply = 8'hA5;
        doReset();
        txEn = 1'b1;
        rxEn = 1'b1;
        // Every mode and order, single byte
        for (int m = 0; m < 8; m++) begin
            {lsb, cpol, cpha} = 3'(m);
            div = 12'(m % 3);
            resync = 1'b1;
            if (m[0]) txcAck = 1'b1;
            else txcClr = 1'b1;
            tick(2);
            {resync, txcAck, txcClr} = '0;
            check("tcfCleared", 0, tcf);
            writeBurst(1);
            waitDone();
            check("halfPeriod", div + 1, halfSeen);
            check("idleLines", {cpol, 2'h3}, {sclk, mosi, oe});
            check("errFlags", 0, {fe, ovr, par});
            readRx();
        end
        // Two bytes back to back give one completion
        f0 = frames;
        writeBurst(2);
        while (frames == f0) tick();
        check("tcfAfterFirst", 0, tcf);
        waitDone();
        check("twoFrames", f0 + 2, frames);
        readRx();
        readRx();
        // Queue filled until refused, receive overflow keeps the oldest
        div = 12'h003;
        writeBurst(6);
        check("queueFull", 0, tbe);
        waitDone();
        readRx();
        readRx();
        check("rxEmpty", 0, rcf);
        // Transmitter alone
        rxEn = 1'b0;
        writeBurst(1);
        waitDone();
        check("rxOff", 0, rcf);
        // Reserved mode starts nothing, then a second reset
        modeSel = 2'h2;
        f0 = frames;
        writeBurst(1);
        tick(60);
        check("noFrame", f0, frames);
        doReset();
        printVerdict();
    end
endmodule
